// >>> dv/eight_bit_timer_counter_tb.sv
// Self-checking bench for the eight bit timer/counter over APB.
// Assumes prdata is captured at the end of setup; the master waits on pready
// with no cycle limit of its own, so only the watchdog ends a hung transfer.
`default_nettype none
module eight_bit_timer_counter_tb;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [7:0] A_CNT = tmr8_pkg::OFF_COUNT;
  localparam logic [7:0] A_CTL = tmr8_pkg::OFF_CTRL;
  localparam logic [7:0] A_STA = tmr8_pkg::OFF_STATUS;
  localparam logic [7:0] A_MSK = tmr8_pkg::OFF_MASK;

  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        sleep_mode;
  logic        irq;
  logic        ext_count_pin;
  logic [31:0] rd;
  logic        err;
  logic [7:0]  c1;
  int          fails;
  int          n_tests;

  tmr8_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_count_pin(ext_count_pin), .sleep_mode(sleep_mode), .irq(irq));
  ext_pin_model model (.pclk(pclk), .pin(ext_count_pin));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // The setup edge is the second edge after entry, so a read reflects the
  // count as it stood after the first edge.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    close_out();
  end

  initial begin
    presetn    = 1'b0;
    psel       = 1'b0;
    penable    = 1'b0;
    pwrite     = 1'b0;
    paddr      = 8'h00;
    pwdata     = 32'h0;
    sleep_mode = 1'b0;
    fails      = 0;
    n_tests    = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, A_CNT, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, A_CTL, 32'h0);
    check(rd, 32'h3F);
    apb(1'b0, A_STA, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, A_MSK, 32'h0);
    check({31'h0, err}, 32'h0);
    check(rd, 32'h0);
    check({31'h0, pready}, 32'h1);
    apb(1'b1, 8'h10, 32'hFF);
    check({31'h0, err}, 32'h1);
    apb(1'b0, 8'h10, 32'h0);
    check(rd, 32'h0);
    apb(1'b1, A_CTL, 32'hFFFF_FFD5);
    apb(1'b0, A_CTL, 32'h0);
    check(rd, 32'h15);
    $display("test registers done");

    apb(1'b1, A_CTL, 32'h08);
    apb(1'b1, A_CNT, 32'hFE);
    apb(1'b0, A_CNT, 32'h0);
    check(rd, 32'hFE);
    repeat (4) @(posedge pclk);
    apb(1'b0, A_CNT, 32'h0);
    check(rd, 32'hFE);
    repeat (1) @(posedge pclk);
    apb(1'b0, A_CNT, 32'h0);
    check(rd, 32'hFF);
    repeat (1) @(posedge pclk);
    apb(1'b0, A_CNT, 32'h0);
    check(rd, 32'h00);
    apb(1'b0, A_STA, 32'h0);
    check(rd, 32'h1);
    check({31'h0, irq}, 32'h0);
    apb(1'b1, A_STA, 32'h0);
    apb(1'b0, A_STA, 32'h0);
    check(rd, 32'h1);
    apb(1'b1, A_MSK, 32'h1);
    @(negedge pclk);
    check({31'h0, irq}, 32'h1);
    apb(1'b1, A_STA, 32'h1);
    apb(1'b0, A_STA, 32'h0);
    check(rd, 32'h0);
    @(negedge pclk);
    check({31'h0, irq}, 32'h0);
    $display("test timer overflow done");

    apb(1'b1, A_CNT, 32'h80);
    sleep_mode <= 1'b1;
    repeat (40) @(posedge pclk);
    apb(1'b0, A_CNT, 32'h0);
    check(rd, 32'h80);
    sleep_mode <= 1'b0;
    $display("test sleep done");

    // Over exactly eight times the ratio in cycles, any prescaler phase
    // yields exactly two increments.
    for (int r = -1; r < 8; r++) begin
      apb(1'b1, A_CTL, (r < 0) ? 32'h08 : 32'(r));
      apb(1'b1, A_CNT, 32'h0);
      repeat (12) @(posedge pclk);
      apb(1'b0, A_CNT, 32'h0);
      c1 = rd[7:0];
      repeat (8 * ((r < 0) ? 1 : (2 << r)) - 3) @(posedge pclk);
      apb(1'b0, A_CNT, 32'h0);
      check(rd, {24'h0, c1 + 8'h02});
    end
    $display("test prescaler done");

    apb(1'b1, A_STA, 32'h1);
    apb(1'b1, A_CTL, 32'h28);
    apb(1'b1, A_CNT, 32'h5A);
    repeat (12) @(posedge pclk);
    model.toggle(5);
    repeat (16) @(posedge pclk);
    apb(1'b0, A_CNT, 32'h0);
    check(rd, 32'h5D);
    apb(1'b1, A_CTL, 32'h38);
    apb(1'b1, A_CNT, 32'hFF);
    repeat (12) @(posedge pclk);
    model.toggle(3);
    repeat (16) @(posedge pclk);
    apb(1'b0, A_CNT, 32'h0);
    check(rd, 32'h01);
    apb(1'b0, A_STA, 32'h0);
    check(rd, 32'h1);
    // Four rising edges through a 1:2 prescaler give two increments.
    apb(1'b1, A_CTL, 32'h20);
    apb(1'b1, A_CNT, 32'h10);
    repeat (12) @(posedge pclk);
    model.toggle(8);
    repeat (16) @(posedge pclk);
    apb(1'b0, A_CNT, 32'h0);
    check(rd, 32'h12);
    $display("test counter done");

    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, A_STA, 32'h0);
    check(rd, 32'h0);
    check({31'h0, irq}, 32'h0);
    apb(1'b0, A_CNT, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, A_CTL, 32'h0);
    check(rd, 32'h3F);
    $display("test reset done");
    close_out();
  end
endmodule
`default_nettype wire

// >>> dv/ext_pin_model.sv
// Far side model of the external count pin: a clean, slow pulse source.
// Assumes pclk is the bench clock and the pin idles low after time zero.
`default_nettype none
module ext_pin_model (
  // Clock
  input  wire logic pclk,
  // Count pin
  output logic      pin
);
  timeunit 1ns;
  timeprecision 1ps;

  initial pin = 1'b0;

  // Each level is held nine cycles so the three flop synchroniser and the
  // quarter phase sampling always see it; faster pins are out of spec.
  task automatic toggle(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge pclk);
      pin <= ~pin;
      repeat (8) @(posedge pclk);
    end
  endtask
endmodule
`default_nettype wire

// >>> src/pin_edge_sync.sv
// Synchroniser and edge selector for the external count pin.
// Assumes the pin may change at any time relative to pclk.
`default_nettype none
module pin_edge_sync (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Pin and edge choice
  input  wire logic pin,
  input  wire logic falling_sel,
  // One cycle pulse on the selected edge
  output logic      edge_pulse
);
  logic meta_q;
  logic sync_q;
  logic last_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end else begin
      meta_q <= pin;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign edge_pulse = falling_sel ? (last_q & ~sync_q) : (~last_q & sync_q);

  property p_edge_dir;
    @(posedge pclk) disable iff (!presetn)
    edge_pulse |-> (falling_sel ? $fell(sync_q) : $rose(sync_q));
  endproperty
  a_edge_dir: assert property (p_edge_dir) else $error("wrong pin edge taken");
endmodule
`default_nettype wire

// >>> src/tmr8_pkg.sv
// Package for the eight bit timer/counter: register map, field layout,
// reset values, quarter phase encoding and the control carrier struct.
// Assumes a 32-bit APB bus with word aligned registers.
`default_nettype none
package tmr8_pkg;

  // Register byte offsets.
  localparam logic [7:0] OFF_COUNT  = 8'h00;
  localparam logic [7:0] OFF_CTRL   = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_MASK   = 8'h0C;

  // Control register field positions.
  localparam int CTRL_RATE_LSB  = 0;
  localparam int CTRL_BYPASS    = 3;
  localparam int CTRL_EDGE      = 4;
  localparam int CTRL_SRC       = 5;
  // Status and mask bit position.
  localparam int OVF_BIT        = 0;

  // Reset values.
  localparam logic [7:0] COUNT_RST  = 8'h00;
  localparam logic [5:0] CTRL_RST   = 6'h3F;
  localparam logic       FLAG_RST   = 1'b0;
  localparam logic       MASK_RST   = 1'b0;

  // Timing: count inhibit after a write, in instruction cycles.
  localparam logic [1:0] INHIBIT_CYCLES = 2'h2;

  // Four quarter phases make one instruction cycle.
  typedef enum logic [1:0] {
    PH_Q1 = 2'b00,
    PH_Q2 = 2'b01,
    PH_Q3 = 2'b10,
    PH_Q4 = 2'b11
  } phase_t;

  typedef struct packed {
    logic       count_source_select;
    logic       source_edge_select;
    logic       prescale_bypass;
    logic [2:0] prescale_rate;
  } ctrl_t;

endpackage
`default_nettype wire

// >>> src/tmr8_top.sv
// Eight bit timer/counter with a private prescaler, APB register access,
// and a level overflow interrupt. The instruction cycle is four pclk cycles.
// Assumes ext_count_pin is a slow external signal and sleep_mode is synchronous.
`default_nettype none
module tmr8_top (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Device pins
  input  wire logic        ext_count_pin,
  input  wire logic        sleep_mode,
  output logic             irq
);

  tmr8_pkg::phase_t phase_q;
  tmr8_pkg::ctrl_t  ctrl_q;
  logic [7:0]       count_value_q;
  logic [7:0]       ps_q;
  logic [1:0]       inhibit_q;
  logic             pend_q;
  logic             overflow_flag_q;
  logic             overflow_irq_enable_q;
  logic [31:0]      prdata_q;

  logic             setup;
  logic             access_w;
  logic             wr_count;
  logic             wr_ctrl;
  logic             wr_status;
  logic             wr_mask;
  logic             mapped;
  logic             instr_tick;
  logic             sample_tick;
  logic             pin_edge;
  logic [7:0]       ps_lim;
  logic             src_event;
  logic             ps_wrap;
  logic             inc;

  // Bus decode. The slave never inserts wait states.
  assign pready    = 1'b1;
  assign setup     = psel & ~penable;
  assign access_w  = psel & penable & pwrite;
  assign mapped    = (paddr == tmr8_pkg::OFF_COUNT) || (paddr == tmr8_pkg::OFF_CTRL) ||
                     (paddr == tmr8_pkg::OFF_STATUS) || (paddr == tmr8_pkg::OFF_MASK);
  assign pslverr   = psel & penable & ~mapped;
  assign wr_count  = access_w & (paddr == tmr8_pkg::OFF_COUNT);
  assign wr_ctrl   = access_w & (paddr == tmr8_pkg::OFF_CTRL);
  assign wr_status = access_w & (paddr == tmr8_pkg::OFF_STATUS);
  assign wr_mask   = access_w & (paddr == tmr8_pkg::OFF_MASK);
  assign prdata    = prdata_q;

  // Read data is captured in the setup cycle so that it is a flop output.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      unique case (paddr)
        tmr8_pkg::OFF_COUNT:  prdata_q <= {24'h00_0000, count_value_q};
        tmr8_pkg::OFF_CTRL:   prdata_q <= {26'h0, ctrl_q};
        tmr8_pkg::OFF_STATUS: prdata_q <= {31'h0, overflow_flag_q};
        tmr8_pkg::OFF_MASK:   prdata_q <= {31'h0, overflow_irq_enable_q};
        default:              prdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // Control register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= tmr8_pkg::CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_q.count_source_select <= pwdata[tmr8_pkg::CTRL_SRC];
      ctrl_q.source_edge_select  <= pwdata[tmr8_pkg::CTRL_EDGE];
      ctrl_q.prescale_bypass     <= pwdata[tmr8_pkg::CTRL_BYPASS];
      ctrl_q.prescale_rate       <= pwdata[tmr8_pkg::CTRL_RATE_LSB +: 3];
    end
  end

  // Quarter phase sequencer; it keeps running in sleep so the bus stays usable.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_q <= tmr8_pkg::PH_Q1;
    end else begin
      unique case (phase_q)
        tmr8_pkg::PH_Q1: phase_q <= tmr8_pkg::PH_Q2;
        tmr8_pkg::PH_Q2: phase_q <= tmr8_pkg::PH_Q3;
        tmr8_pkg::PH_Q3: phase_q <= tmr8_pkg::PH_Q4;
        tmr8_pkg::PH_Q4: phase_q <= tmr8_pkg::PH_Q1;
      endcase
    end
  end

  assign instr_tick  = (phase_q == tmr8_pkg::PH_Q4);
  assign sample_tick = (phase_q == tmr8_pkg::PH_Q2) || (phase_q == tmr8_pkg::PH_Q4);

  pin_edge_sync u_pin (
    .pclk        (pclk),
    .presetn     (presetn),
    .pin         (ext_count_pin),
    .falling_sel (ctrl_q.source_edge_select),
    .edge_pulse  (pin_edge)
  );

  // Source events: instruction cycles in timer mode, pin edges otherwise.
  assign src_event = ctrl_q.count_source_select ? pin_edge : instr_tick;

  // The prescaler is private to this timer and never visible on the bus.
  assign ps_lim  = 8'hFF >> (3'h7 - ctrl_q.prescale_rate);
  assign ps_wrap = src_event & ~ctrl_q.prescale_bypass & (ps_q == ps_lim);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ps_q <= 8'h00;
    end else if (wr_count) begin
      ps_q <= 8'h00;
    end else if (!sleep_mode && src_event && !ctrl_q.prescale_bypass) begin
      ps_q <= ps_wrap ? 8'h00 : ps_q + 8'h01;
    end
  end

  // Counter mode events wait here until the next Q2 or Q4 sample point.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_q <= 1'b0;
    end else if (wr_count || !ctrl_q.count_source_select) begin
      pend_q <= 1'b0;
    end else if (!sleep_mode && (ctrl_q.prescale_bypass ? pin_edge : ps_wrap)) begin
      pend_q <= 1'b1;
    end else if (sample_tick) begin
      pend_q <= 1'b0;
    end
  end

  // Write inhibit counts down on instruction cycle boundaries.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      inhibit_q <= 2'h0;
    end else if (wr_count) begin
      inhibit_q <= tmr8_pkg::INHIBIT_CYCLES;
    end else if (instr_tick && inhibit_q != 2'h0) begin
      inhibit_q <= inhibit_q - 2'h1;
    end
  end

  always_comb begin
    inc = 1'b0;
    if (!sleep_mode && inhibit_q == 2'h0) begin
      if (ctrl_q.count_source_select) begin
        inc = pend_q & sample_tick;
      end else if (ctrl_q.prescale_bypass) begin
        inc = instr_tick;
      end else begin
        inc = ps_wrap;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_value_q <= tmr8_pkg::COUNT_RST;
    end else if (wr_count) begin
      count_value_q <= pwdata[7:0];
    end else if (inc) begin
      count_value_q <= count_value_q + 8'h01;
    end
  end

  // A new overflow beats a software clear in the same cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow_flag_q <= tmr8_pkg::FLAG_RST;
    end else if (inc && count_value_q == 8'hFF && !wr_count) begin
      overflow_flag_q <= 1'b1;
    end else if (wr_status && pwdata[tmr8_pkg::OVF_BIT]) begin
      overflow_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow_irq_enable_q <= tmr8_pkg::MASK_RST;
    end else if (wr_mask) begin
      overflow_irq_enable_q <= pwdata[tmr8_pkg::OVF_BIT];
    end
  end

  assign irq = overflow_flag_q & overflow_irq_enable_q;

  // Checks.
  property p_count_write;
    @(posedge pclk) disable iff (!presetn)
    wr_count |=> (count_value_q == $past(pwdata[7:0]));
  endproperty
  a_count_write: assert property (p_count_write) else $error("count write lost");

  property p_inhibit;
    @(posedge pclk) disable iff (!presetn)
    wr_count ##1 !wr_count [*4] |-> $stable(count_value_q);
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("count moved during inhibit");

  property p_timer_step;
    @(posedge pclk) disable iff (!presetn)
    (!ctrl_q.count_source_select && ctrl_q.prescale_bypass && instr_tick &&
     inhibit_q == 2'h0 && !sleep_mode && !wr_count)
    |=> (count_value_q == $past(count_value_q) + 8'h01);
  endproperty
  a_timer_step: assert property (p_timer_step) else $error("timer missed a cycle");

  property p_sleep_hold;
    @(posedge pclk) disable iff (!presetn)
    (sleep_mode && !wr_count) |=> $stable(count_value_q);
  endproperty
  a_sleep_hold: assert property (p_sleep_hold) else $error("count moved in sleep");

  property p_ovf_flag;
    @(posedge pclk) disable iff (!presetn)
    (inc && count_value_q == 8'hFF && !wr_count)
    |=> (overflow_flag_q && count_value_q == 8'h00);
  endproperty
  a_ovf_flag: assert property (p_ovf_flag) else $error("overflow not flagged");

  property p_irq_rise;
    @(posedge pclk) disable iff (!presetn)
    $rose(irq) |-> ($past(inc) && $past(count_value_q) == 8'hFF) || $past(wr_mask);
  endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("irq without cause");

  property p_ps_clear;
    @(posedge pclk) disable iff (!presetn)
    wr_count |=> (ps_q == 8'h00);
  endproperty
  a_ps_clear: assert property (p_ps_clear) else $error("prescaler not cleared");

  property p_ratio;
    @(posedge pclk) disable iff (!presetn)
    (inc && !ctrl_q.count_source_select && !ctrl_q.prescale_bypass)
    |-> (ps_q == ps_lim) ##1 (ps_q == 8'h00);
  endproperty
  a_ratio: assert property (p_ratio) else $error("prescale ratio wrong");

  property p_sample_phase;
    @(posedge pclk) disable iff (!presetn)
    (ctrl_q.count_source_select && inc)
    |-> (phase_q == tmr8_pkg::PH_Q2 || phase_q == tmr8_pkg::PH_Q4);
  endproperty
  a_sample_phase: assert property (p_sample_phase) else $error("sampled off phase");

  property p_flag_hold;
    @(posedge pclk) disable iff (!presetn)
    (overflow_flag_q && !(wr_status && pwdata[tmr8_pkg::OVF_BIT])) |=> overflow_flag_q;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag cleared by hardware");

  property p_timer_phase;
    @(posedge pclk) disable iff (!presetn)
    (!ctrl_q.count_source_select && inc) |-> (phase_q == tmr8_pkg::PH_Q4);
  endproperty
  a_timer_phase: assert property (p_timer_phase) else $error("timer off cycle");

  property p_inhibit_hold;
    @(posedge pclk) disable iff (!presetn)
    (inhibit_q != 2'h0 && !wr_count) |=> $stable(count_value_q);
  endproperty
  a_inhibit_hold: assert property (p_inhibit_hold) else $error("inhibit ignored");

  property p_ps_sleep;
    @(posedge pclk) disable iff (!presetn)
    (sleep_mode && !wr_count) |=> $stable(ps_q);
  endproperty
  a_ps_sleep: assert property (p_ps_sleep) else $error("prescaler ran in sleep");

  property p_ps_bypass;
    @(posedge pclk) disable iff (!presetn)
    (ctrl_q.prescale_bypass && !wr_count) |=> $stable(ps_q);
  endproperty
  a_ps_bypass: assert property (p_ps_bypass) else $error("bypassed prescaler ran");

  property p_pend_clear;
    @(posedge pclk) disable iff (!presetn)
    wr_count |=> !pend_q;
  endproperty
  a_pend_clear: assert property (p_pend_clear) else $error("pending kept on write");

  // The flag may only rise where the count has just wrapped to zero.
  property p_ovf_only;
    @(posedge pclk) disable iff (!presetn)
    $rose(overflow_flag_q) |-> ($past(count_value_q) == 8'hFF && count_value_q == 8'h00);
  endproperty
  a_ovf_only: assert property (p_ovf_only) else $error("flag without wrap");

  property p_sleep_no_flag;
    @(posedge pclk) disable iff (!presetn)
    (sleep_mode && !overflow_flag_q) |=> !overflow_flag_q;
  endproperty
  a_sleep_no_flag: assert property (p_sleep_no_flag) else $error("flag set in sleep");

  // Without a write the count either holds or steps by exactly one.
  property p_count_step;
    @(posedge pclk) disable iff (!presetn)
    !wr_count |=> (count_value_q == $past(count_value_q) ||
                   count_value_q == $past(count_value_q) + 8'h01);
  endproperty
  a_count_step: assert property (p_count_step) else $error("count jumped");

  property p_pin_pend;
    @(posedge pclk) disable iff (!presetn)
    (ctrl_q.count_source_select && ctrl_q.prescale_bypass && pin_edge && !sleep_mode &&
     !wr_count) |=> pend_q;
  endproperty
  a_pin_pend: assert property (p_pin_pend) else $error("pin edge lost");

  c_overflow: cover property (@(posedge pclk) disable iff (!presetn) $rose(overflow_flag_q));
  c_irq:      cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
  c_pin_inc:  cover property (@(posedge pclk) disable iff (!presetn)
                              ctrl_q.count_source_select && inc);
  c_ps_pin:   cover property (@(posedge pclk) disable iff (!presetn)
                              ctrl_q.count_source_select && !ctrl_q.prescale_bypass && inc);

endmodule
`default_nettype wire
